// *** design/tbo_button_ctrl.sv ***
// touch button output control: straps, self test result, toggle, flank, on-time, auto reset
// Contract
// - outputs follow own touch, active low
// - failed button: 5 ms low pulse at 175 ms
// - deep sleep drives every output high
// - sleep holds each output at its level
// - reset releases outputs to high impedance
// - toggle mode inverts output per touch
// - flank suppression: lone touch reports on
// - flank suppression: earlier touched button wins
// - on-time keeps output low after release
// - no on-time after auto reset
// - new release restarts on-time, old ends
// - on-time 0 to 2000 ms, 20 ms steps
// - auto reset after 5 or 20 s
// - hold after auto reset 220 ms or scan+200
// - ground short disables button
// - supply short disables button
// - shorted group all disabled
// - bad modulator cap disables all
// - parasitic cap over limit disables button
// - straps captured once after every reset
module tbo_button_ctrl #(
    parameter int MS_CYC = tbo_pkg::MS_CYCLES            // clocks per ms, shorten in simulation
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        externalResetPin,            // device reset pin, active high
    input  wire logic [3:0]  touchInput,                  // sensed touches, high = touched
    input  wire logic        strapToggle,                 // toggle feature strap
    input  wire logic        strapFlank,                  // flank suppression strap
    input  wire logic        autoReleaseStrap,            // auto reset enable strap
    input  wire logic        strapAuto20,                 // auto reset period 20 s, else 5 s
    input  wire logic [6:0]  strapOnSteps,                // on-time in 20 ms steps
    input  wire logic [7:0]  scanPeriodSetting,           // scan period in ms
    input  wire logic [3:0]  faultGround,                 // self test: shorted to ground
    input  wire logic [3:0]  faultSupply,                 // self test: shorted to supply
    input  wire logic [3:0]  faultBridge,                 // self test: shorted to another button
    input  wire logic        modulatorCapBad,             // self test: cap below 1 nF or over 4 nF
    input  wire logic [3:0]  parasiticCapHigh,            // self test: cap over 40 pF
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [3:0]  buttonOutput,                // pin level, low = on
    output logic      [3:0]  buttonOutputOe               // high while the pin is driven
);
    if (MS_CYC < 2 || MS_CYC > 32768) begin : g_chk
        $error("MS_CYC out of range");
    end

    // all state of the block
    typedef struct packed {
        tbo_pkg::tbo_phase_t phase;
        logic [14:0]         msCnt;      // clocks within the current ms
        logic [7:0]          postMs;     // ms since power-up during self test
        logic [7:0]          scanMs;     // ms within the current scan
        logic                togCfg;
        logic                flkCfg;
        logic                areCfg;
        logic                ar20Cfg;
        logic [6:0]          onSteps;
        logic [7:0]          scanCfg;
        logic [3:0]          disabled;   // buttons removed from service
        logic [3:0]          rep;        // reported touches
        logic [3:0]          tog;        // latched toggle states
        logic [3:0]          arFlag;     // auto reset fired, waiting for release
        logic [3:0]          holdOn;     // held off after auto reset
        logic [3:0][14:0]    autoCnt;    // ms of continuous reported touch
        logic [3:0][10:0]    pressCnt;   // ms pressed since auto reset
        logic [3:0][9:0]     holdCnt;    // ms of hold left
        logic [11:0]         onCnt;      // ms of on-time left, one shared counter
        logic [1:0]          onOwner;    // button that owns the on-time
        logic [3:0]          outLevel;   // pin levels
        logic                oe;
        logic                sleep;
        logic                deep;
        logic [31:0]         rdData;
        logic                dpWrite;    // data phase of a write pending
        logic [7:0]          dpAddr;
    } tbo_state_t;

    tbo_state_t s_ff;
    tbo_state_t nxt_s;
    logic       rst;                     // either reset source
    logic       msTick;                  // one clock per ms
    logic       scanTick;                // one clock per scan
    logic [3:0] gated;                   // touches allowed through
    logic [3:0] newRep;                  // reported touches after flank logic
    logic [3:0] activeLow;               // which outputs are on
    logic [14:0] arLimit;                // selected auto reset period in ms

    assign rst      = srst | externalResetPin;
    assign msTick   = (s_ff.msCnt == 15'(MS_CYC - 1));
    assign scanTick = msTick && (s_ff.scanMs + 8'h01 >= s_ff.scanCfg);
    assign arLimit  = s_ff.ar20Cfg ? 15'(tbo_pkg::AR_LONG_MS) : 15'(tbo_pkg::AR_SHORT_MS);
    assign hreadyout = 1'b1;             // zero wait states, read data prepared in address phase
    assign hresp     = 1'b0;
    assign hrdata    = s_ff.rdData;
    assign buttonOutput   = s_ff.outLevel;
    assign buttonOutputOe = s_ff.oe ? 4'hf : 4'h0;

    // flank suppression on the gated touches
    always_comb begin
        gated = touchInput & ~s_ff.disabled & ~s_ff.arFlag & ~s_ff.holdOn;
        if (!s_ff.flkCfg || $countones(gated) <= 1) begin
            newRep = gated;
        end else begin
            newRep = gated & s_ff.rep;
            if ($countones(newRep) > 1) begin
                newRep = 4'h0;                           // no single earlier winner
            end
        end
    end

    // next state
    always_comb begin
        nxt_s = s_ff;
        activeLow = 4'h0;
        // millisecond timebase
        nxt_s.msCnt = msTick ? 15'h0000 : s_ff.msCnt + 15'h0001;
        // bus address phase: latch write, prepare read data
        nxt_s.dpWrite = 1'b0;
        if (hsel && hready && htrans[tbo_pkg::HTRANS_ACT_BIT]) begin
            nxt_s.dpWrite = hwrite;
            nxt_s.dpAddr  = haddr[7:0];
            nxt_s.rdData  = 32'h00000000;                // unmapped reads as zero
            if (!hwrite) begin
                unique case (haddr[7:0])
                    tbo_pkg::CTRL_OFS: begin
                        nxt_s.rdData[tbo_pkg::CTRL_SLEEP_BIT] = s_ff.sleep;
                        nxt_s.rdData[tbo_pkg::CTRL_DEEP_BIT]  = s_ff.deep;
                    end
                    tbo_pkg::STATUS_OFS: begin
                        nxt_s.rdData[tbo_pkg::ST_REP_LSB +: 4] = s_ff.rep;
                        nxt_s.rdData[tbo_pkg::ST_OUT_LSB +: 4] = s_ff.outLevel;
                        nxt_s.rdData[tbo_pkg::ST_DIS_LSB +: 4] = s_ff.disabled;
                        nxt_s.rdData[tbo_pkg::ST_RUN_BIT]      = (s_ff.phase == tbo_pkg::PH_RUN);
                    end
                    tbo_pkg::CONFIG_OFS: begin
                        nxt_s.rdData[tbo_pkg::CF_TOG_BIT]       = s_ff.togCfg;
                        nxt_s.rdData[tbo_pkg::CF_FLK_BIT]       = s_ff.flkCfg;
                        nxt_s.rdData[tbo_pkg::CF_ARE_BIT]       = s_ff.areCfg;
                        nxt_s.rdData[tbo_pkg::CF_AR20_BIT]      = s_ff.ar20Cfg;
                        nxt_s.rdData[tbo_pkg::CF_ON_LSB +: 7]   = s_ff.onSteps;
                        nxt_s.rdData[tbo_pkg::CF_SCAN_LSB +: 8] = s_ff.scanCfg;
                    end
                    default: begin
                    end
                endcase
            end
        end
        // bus data phase: only the control word is writable
        if (s_ff.dpWrite && s_ff.dpAddr == tbo_pkg::CTRL_OFS) begin
            nxt_s.sleep = hwdata[tbo_pkg::CTRL_SLEEP_BIT];
            nxt_s.deep  = hwdata[tbo_pkg::CTRL_DEEP_BIT];
        end
        unique case (s_ff.phase)
            tbo_pkg::PH_CAPTURE: begin
                // straps and self test results are taken once, the first clock after reset
                nxt_s.togCfg   = strapToggle;
                nxt_s.flkCfg   = strapFlank;
                nxt_s.areCfg   = autoReleaseStrap;
                nxt_s.ar20Cfg  = strapAuto20;
                nxt_s.onSteps  = (strapOnSteps > 7'(tbo_pkg::ONTIME_MAX_STEP)) ?
                                 7'(tbo_pkg::ONTIME_MAX_STEP) : strapOnSteps;
                nxt_s.scanCfg  = (scanPeriodSetting == 8'h00) ? 8'h01 : scanPeriodSetting;
                nxt_s.disabled = faultGround | faultSupply | faultBridge
                               | parasiticCapHigh
                               | {4{modulatorCapBad}};
                nxt_s.outLevel = 4'hf;
                nxt_s.oe       = 1'b1;
                nxt_s.msCnt    = 15'h0000;
                nxt_s.phase    = tbo_pkg::PH_POWER_ON_SELF_TEST;
            end
            tbo_pkg::PH_POWER_ON_SELF_TEST: begin
                // failed buttons pulse low once, the others stay high
                if (msTick) begin
                    nxt_s.postMs = s_ff.postMs + 8'h01;
                end
                if (s_ff.postMs >= 8'(tbo_pkg::POWER_ON_SELF_TEST_DELAY_MS) &&
                    s_ff.postMs < 8'(tbo_pkg::POWER_ON_SELF_TEST_DELAY_MS + tbo_pkg::POWER_ON_SELF_TEST_PULSE_MS)) begin
                    nxt_s.outLevel = ~s_ff.disabled;
                end else begin
                    nxt_s.outLevel = 4'hf;
                end
                if (msTick && s_ff.postMs == 8'(tbo_pkg::POWER_ON_SELF_TEST_DELAY_MS + tbo_pkg::POWER_ON_SELF_TEST_PULSE_MS)) begin
                    nxt_s.phase = tbo_pkg::PH_RUN;
                end
            end
            tbo_pkg::PH_RUN: begin
                if (s_ff.deep) begin
                    nxt_s.outLevel = 4'hf;
                end else if (!s_ff.sleep) begin
                    // sleep skips every update so outputs and timers stay put
                    if (msTick) begin
                        nxt_s.scanMs = scanTick ? 8'h00 : s_ff.scanMs + 8'h01;
                        if (s_ff.onCnt != 12'h000) begin
                            nxt_s.onCnt = s_ff.onCnt - 12'h001;
                        end
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (scanTick) begin
                            nxt_s.rep[i] = newRep[i];
                            if (newRep[i] && !s_ff.rep[i]) begin
                                nxt_s.tog[i] = ~s_ff.tog[i];
                            end
                            if (!newRep[i] && s_ff.rep[i]) begin
                                // a later release takes the counter over
                                nxt_s.onCnt   = 12'(s_ff.onSteps * tbo_pkg::ONTIME_STEP_MS);
                                nxt_s.onOwner = 2'(i);
                            end
                        end
                        if (!nxt_s.rep[i]) begin
                            nxt_s.autoCnt[i] = 15'h0000;
                        end else if (msTick && s_ff.areCfg) begin
                            nxt_s.autoCnt[i] = s_ff.autoCnt[i] + 15'h0001;
                            if (s_ff.autoCnt[i] + 15'h0001 >= arLimit) begin
                                nxt_s.rep[i]      = 1'b0;
                                nxt_s.autoCnt[i]  = 15'h0000;
                                nxt_s.arFlag[i]   = 1'b1;                  // no on-time load
                                nxt_s.pressCnt[i] = 11'h000;
                                if (s_ff.onOwner == 2'(i)) begin
                                    nxt_s.onCnt = 12'h000;
                                end
                            end
                        end
                        if (s_ff.arFlag[i] && msTick) begin
                            if (touchInput[i]) begin
                                if (s_ff.pressCnt[i] < 11'(tbo_pkg::PRESS_LIMIT_MS)) begin
                                    nxt_s.pressCnt[i] = s_ff.pressCnt[i] + 11'h001;
                                end
                            end else begin
                                nxt_s.arFlag[i] = 1'b0;
                                nxt_s.holdOn[i] = 1'b1;
                                nxt_s.holdCnt[i] = (s_ff.pressCnt[i] < 11'(tbo_pkg::PRESS_LIMIT_MS)) ?
                                    10'(tbo_pkg::HOLD_SHORT_MS) :
                                    10'(s_ff.scanCfg) + 10'(tbo_pkg::HOLD_EXTRA_MS);
                            end
                        end
                        if (s_ff.holdOn[i] && msTick) begin
                            nxt_s.holdCnt[i] = s_ff.holdCnt[i] - 10'h001;
                            if (s_ff.holdCnt[i] <= 10'h001) begin
                                nxt_s.holdOn[i] = 1'b0;
                            end
                        end
                        activeLow[i] = (s_ff.togCfg ? s_ff.tog[i] : s_ff.rep[i])
                                     | (s_ff.onCnt != 12'h000 && s_ff.onOwner == 2'(i));
                    end
                    nxt_s.outLevel = ~(activeLow & ~s_ff.disabled);
                end
            end
            default: begin
                nxt_s.phase = tbo_pkg::PH_CAPTURE;
            end
        endcase
    end

    // state register, reset releases the pins
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_ff       <= '0;
            s_ff.phase <= tbo_pkg::PH_CAPTURE;
            s_ff.outLevel <= 4'hf;
            s_ff.scanCfg  <= 8'h01;
        end else begin
            s_ff <= nxt_s;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_deep;
        s_ff.phase == tbo_pkg::PH_RUN && s_ff.deep |=> buttonOutput == 4'hf && buttonOutputOe == 4'hf;
    endproperty
    a_deep: assert property (p_deep) else $error("deep sleep output not high");

    property p_sleep;
        s_ff.phase == tbo_pkg::PH_RUN && s_ff.sleep && !s_ff.deep && $past(s_ff.sleep) |=> $stable(buttonOutput);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep output moved");

    property p_reset;
        disable iff (1'b0) rst |=> buttonOutputOe == 4'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("output driven in reset");

    property p_disabled;
        s_ff.phase == tbo_pkg::PH_RUN ##1 s_ff.phase == tbo_pkg::PH_RUN |-> (s_ff.disabled & ~buttonOutput) == 4'h0;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled button driven low");

    property p_flank;
        s_ff.flkCfg |-> $countones(s_ff.rep) <= 1;
    endproperty
    a_flank: assert property (p_flank) else $error("several buttons reported");

    property p_toggle;
        s_ff.togCfg && $rose(s_ff.rep[0]) |-> s_ff.tog[0] != $past(s_ff.tog[0]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle did not invert");

    property p_ontime;
        s_ff.onCnt <= 12'(tbo_pkg::ONTIME_MAX_MS);
    endproperty
    a_ontime: assert property (p_ontime) else $error("on-time above limit");

    property p_auto;
        s_ff.areCfg && $rose(s_ff.arFlag[0]) |-> !s_ff.rep[0] && $past(s_ff.autoCnt[0]) + 15'h0001 >= arLimit;
    endproperty
    a_auto: assert property (p_auto) else $error("auto reset at wrong time");

    property p_power_on_self_test;
        s_ff.phase == tbo_pkg::PH_POWER_ON_SELF_TEST && s_ff.postMs < 8'(tbo_pkg::POWER_ON_SELF_TEST_DELAY_MS) |=> buttonOutput == 4'hf;
    endproperty
    a_power_on_self_test: assert property (p_power_on_self_test) else $error("output low before pulse");

    property p_strap;
        s_ff.phase == tbo_pkg::PH_RUN |-> $stable(s_ff.onSteps) && $stable(s_ff.disabled) && $stable(s_ff.togCfg);
    endproperty
    a_strap: assert property (p_strap) else $error("configuration changed");

    c_pulse: cover property (s_ff.phase == tbo_pkg::PH_POWER_ON_SELF_TEST && buttonOutput != 4'hf);
    c_ontime: cover property (s_ff.onCnt != 12'h000 && s_ff.rep == 4'h0);
    c_hold: cover property ($rose(s_ff.holdOn[0]));
endmodule

// *** design/tbo_pkg.sv ***
// package for the touch button output control block: map, field positions, timing
package tbo_pkg;
    // clock and millisecond timebase
    localparam int CLK_PERIOD_NS   = 40;                      // mclk at 25 MHz
    localparam int MS_NS           = 1000000;                 // one millisecond
    localparam int MS_CYCLES       = MS_NS / CLK_PERIOD_NS;   // clocks per ms tick
    // self test timing, in ms
    localparam int POWER_ON_SELF_TEST_DELAY_MS   = 175;                     // pulse start after power-up
    localparam int POWER_ON_SELF_TEST_PULSE_MS   = 5;                       // failure pulse length
    // auto reset timing, in ms
    localparam int AR_SHORT_MS     = 5000;                    // short auto reset period
    localparam int AR_LONG_MS      = 20000;                   // long auto reset period
    localparam int PRESS_LIMIT_MS  = 2000;                    // press time that picks the hold
    localparam int HOLD_SHORT_MS   = 220;                     // hold after a short press
    localparam int HOLD_EXTRA_MS   = 200;                     // added to scan period otherwise
    // led on-time, in ms
    localparam int ONTIME_STEP_MS  = 20;                      // on-time resolution
    localparam int ONTIME_MAX_MS   = 2000;                    // longest on-time
    localparam int ONTIME_MAX_STEP = ONTIME_MAX_MS / ONTIME_STEP_MS;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;                // sleep controls, read/write
    localparam logic [7:0] STATUS_OFS = 8'h04;                // live state, read only
    localparam logic [7:0] CONFIG_OFS = 8'h08;                // captured straps, read only
    // control fields
    localparam int CTRL_SLEEP_BIT = 0;                        // low power sleep, outputs frozen
    localparam int CTRL_DEEP_BIT  = 1;                        // deep sleep, outputs driven high
    localparam logic [1:0] CTRL_RESET = 2'h0;                 // awake after reset
    // status fields
    localparam int ST_REP_LSB  = 0;                           // reported touches
    localparam int ST_OUT_LSB  = 4;                           // pin levels
    localparam int ST_DIS_LSB  = 8;                           // disabled buttons
    localparam int ST_RUN_BIT  = 12;                          // self test finished
    // config fields
    localparam int CF_TOG_BIT  = 0;
    localparam int CF_FLK_BIT  = 1;
    localparam int CF_ARE_BIT  = 2;
    localparam int CF_AR20_BIT = 3;
    localparam int CF_ON_LSB   = 8;
    localparam int CF_SCAN_LSB = 16;
    // ahb transfer type bit that marks an active transfer
    localparam int HTRANS_ACT_BIT = 1;
    // block phases
    typedef enum logic [1:0] {PH_CAPTURE, PH_POWER_ON_SELF_TEST, PH_RUN} tbo_phase_t;
endpackage

// *** verification/tbo_led_model.sv ***
// led and pull-up model on the button output pins
module tbo_led_model (
    input  wire logic [3:0] buttonOutput,    // level the block drives
    input  wire logic [3:0] buttonOutputOe,  // high while the block drives the pin
    output logic      [3:0] pinLevel,        // level seen on the wire
    output logic      [3:0] ledOn            // led lit while its pin sinks current
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released pin floats up through the led and resistor to the supply
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pinLevel[i] = buttonOutputOe[i] ? buttonOutput[i] : 1'b1;
        end
        ledOn = ~pinLevel;
    end
endmodule

// *** verification/touch_button_output_control_tb.sv ***
// self-checking bench for the touch button output control block
module touch_button_output_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 10;  // clocks per ms, short so a run stays small
    logic        mclk, srst, externalResetPin, hsel, hwrite, hready, hreadyout, hresp;
    logic        strapToggle, strapFlank, autoReleaseStrap, strapAuto20, modulatorCapBad;
    logic [3:0]  touchInput, faultGround, faultSupply, faultBridge, parasiticCapHigh;
    logic [3:0]  buttonOutput, buttonOutputOe, pinLevel, ledOn;
    logic [6:0]  strapOnSteps;
    logic [7:0]  scanPeriodSetting;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          fails, numChecks;

    tbo_button_ctrl #(.MS_CYC(MSC)) uut (.mclk, .srst, .externalResetPin, .touchInput, .strapToggle, .strapFlank,
        .autoReleaseStrap, .strapAuto20, .strapOnSteps, .scanPeriodSetting, .faultGround, .faultSupply,
        .faultBridge, .modulatorCapBad, .parasiticCapHigh, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .buttonOutput, .buttonOutputOe);
    tbo_led_model leds (.buttonOutput, .buttonOutputOe, .pinLevel, .ledOn);
    assign hready = hreadyout;  // one slave, so its ready is the bus ready

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ms(input int n);
        repeat (n * MSC) @(posedge mclk);
    endtask
    // one single word transfer; waits on ready, never on a fixed latency
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask
    // reset with straps and faults set beforehand, then walk the self test
    task automatic boot(input logic viaPin);
        logic [3:0] dis;
        if (viaPin) begin
            externalResetPin <= 1'b1;
        end else begin
            srst <= 1'b1;
        end
        repeat (3) @(posedge mclk);
        // faults were set by non-blocking assignment just before the call, so read them only now
        dis = modulatorCapBad ? 4'hf : (faultGround | faultSupply | faultBridge | parasiticCapHigh);
        chk(32'(buttonOutputOe), 32'h0);
        srst             <= 1'b0;
        externalResetPin <= 1'b0;
        ms(171);
        chk(32'(pinLevel), 32'hf);
        ms(6);
        chk(32'(pinLevel), {28'h0, ~dis});
        ms(8);
        chk(32'(pinLevel), 32'hf);
        ahb(1'b0, tbo_pkg::STATUS_OFS, 32'h0);
        chk(32'(rd[12:8]), 32'({1'b1, dis}));
        ahb(1'b0, tbo_pkg::CONFIG_OFS, 32'h0);
        chk(rd, 32'({scanPeriodSetting, 1'b0, strapOnSteps, 4'h0, strapAuto20, autoReleaseStrap, strapFlank,
            strapToggle}));
    endtask
    // touch, wait three scans, compare the wire
    task automatic touch(input logic [3:0] t, input logic [3:0] exp);
        touchInput <= t;
        ms(3);
        chk(32'(pinLevel), 32'(exp));
    endtask

    // follow, disabled buttons, register map, sleep and deep sleep
    task automatic testFollow();
        faultGround      <= 4'h4;
        parasiticCapHigh <= 4'h8;
        boot(1'b0);
        touch(4'h5, 4'he);
        chk(32'(ledOn), 32'h1);
        touch(4'h0, 4'hf);
        ahb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, tbo_pkg::STATUS_OFS, 32'hffffffff);
        ahb(1'b0, tbo_pkg::STATUS_OFS, 32'h0);
        chk(32'(rd[11:8]), 32'hc);
        touch(4'h2, 4'hd);
        ahb(1'b1, tbo_pkg::CTRL_OFS, 32'h1);
        touch(4'h0, 4'hd);
        ahb(1'b1, tbo_pkg::CTRL_OFS, 32'h2);
        ms(1);
        chk(32'({buttonOutputOe, pinLevel}), 32'hff);
        ahb(1'b0, tbo_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h2);
        ahb(1'b1, tbo_pkg::CTRL_OFS, 32'h0);
        touch(4'h0, 4'hf);
        $display("test follow done");
    endtask
    // toggle mode, booted from the reset pin; straps are not sampled again
    task automatic testToggle();
        faultGround      <= 4'h0;
        parasiticCapHigh <= 4'h0;
        faultSupply      <= 4'h1;
        faultBridge      <= 4'h6;
        strapToggle      <= 1'b1;
        boot(1'b1);
        strapToggle <= 1'b0;
        touch(4'h8, 4'h7);
        touch(4'h0, 4'h7);
        touch(4'h9, 4'hf);
        touch(4'h0, 4'hf);
        $display("test toggle done");
    endtask
    // bad modulator cap locks every button out
    task automatic testModCap();
        faultSupply     <= 4'h0;
        faultBridge     <= 4'h0;
        modulatorCapBad <= 1'b1;
        boot(1'b0);
        touch(4'hf, 4'hf);
        touch(4'h0, 4'hf);
        $display("test modcap done");
    endtask
    // flank suppression and a 40 ms on-time
    task automatic testFlankOnTime();
        modulatorCapBad <= 1'b0;
        strapFlank      <= 1'b1;
        strapOnSteps    <= 7'h02;
        boot(1'b0);
        touch(4'h1, 4'he);
        touch(4'h3, 4'he);
        touch(4'h0, 4'he);
        ms(17);
        chk(32'(pinLevel), 32'he);
        ms(25);
        chk(32'(pinLevel), 32'hf);
        touch(4'h1, 4'he);
        touch(4'h0, 4'he);
        touch(4'h2, 4'hc);
        touch(4'h0, 4'hd);
        ms(45);
        chk(32'(pinLevel), 32'hf);
        $display("test flank ontime done");
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d, mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // whole run is near 885 ms; over twice that means a hang
    initial begin
        repeat (2000 * MSC) @(posedge mclk);
        fails++;
        conclude();
    end
    initial begin
        {srst, externalResetPin, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {strapToggle, strapFlank, autoReleaseStrap, strapAuto20, modulatorCapBad} = '0;
        {touchInput, faultGround, faultSupply, faultBridge, parasiticCapHigh, strapOnSteps} = '0;
        hsize             = 3'h2;
        scanPeriodSetting = 8'h01;
        fails             = 0;
        numChecks         = 0;
        testFollow();
        testToggle();
        testModCap();
        testFlankOnTime();
        conclude();
    end
endmodule
